// [rtl/peripheral_disable_regs.vh]
// Offsets, field positions, masks and reset values of the peripheral disable registers.
`ifndef PERIPHERAL_DISABLE_REGS_VH
`define PERIPHERAL_DISABLE_REGS_VH

// Byte offsets of the two registers on the bus.
`define OFS_COMPARATOR_TRIGGER 4'h0
`define OFS_LOGIC_CELLS_MISC   4'h4

// Field positions in the first register.
`define POS_COMPARATOR_ONE_OFF  8
`define POS_PATTERN_TRIGGER_OFF 3

// Field positions in the second register.
`define POS_OPAMP_MODULES_OFF   13
`define POS_NIBBLE_TX_ONE_OFF   11
`define POS_DEADMAN_TIMER_OFF   8
`define POS_LOGIC_CELL_FOUR_OFF 5
`define POS_LOGIC_CELL_THREE_OFF 4
`define POS_LOGIC_CELL_TWO_OFF  3
`define POS_LOGIC_CELL_ONE_OFF  2
`define POS_CURRENT_SOURCE_OFF  1

// Masks of the implemented bits.
`define MASK_COMPARATOR_TRIGGER 16'h0108
`define MASK_LOGIC_CELLS_MISC   16'h293E

// Power-on values.
`define RST_COMPARATOR_TRIGGER 16'h0000
`define RST_LOGIC_CELLS_MISC   16'h0000

// Bus responses.
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/peripheral_disable_regs.v]
// AXI4-Lite register bank of per-peripheral disable flags.
`timescale 1ns/1ns
`default_nettype none
`include "peripheral_disable_regs.vh"

module peripheral_disable_regs (
  // Clock and reset.
  input  wire        sys_clk,
  input  wire        rst_n,
  // Write address channel.
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // Write data channel.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // Write response channel.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // Read address channel.
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // Read data channel.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Disable flags to the peripherals, high means disabled.
  output reg         comparator_one_off,
  output reg         pattern_trigger_off,
  output reg         opamp_modules_off,
  output reg         nibble_tx_one_off,
  output reg         deadman_timer_off,
  output reg         logic_cell_four_off,
  output reg         logic_cell_three_off,
  output reg         logic_cell_two_off,
  output reg         logic_cell_one_off,
  output reg         current_source_off
);

  // Register storage and captured write halves.
  // Unimplemented bits are masked on write and again on read, so they never read back as one.
  reg  [15:0] cmp_trig_q;
  reg  [15:0] cells_misc_q;
  reg  [3:0]  waddr_q;
  reg         waddr_ok_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         wdata_ok_q;

  // Merges a write into a 16-bit register under byte strobes and a mask.
  // Only the two low strobes matter, as each register is sixteen bits wide.
  function [15:0] merge;
    input [15:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    input [15:0] mask;
    reg   [15:0] bytes;
    begin
      bytes = {{8{strb[1]}}, {8{strb[0]}}};
      merge = ((old_v & ~bytes) | (new_v[15:0] & bytes)) & mask;
    end
  endfunction

  // Maps a byte address onto a one-hot register select; all zero means unmapped.
  function [1:0] decode_sel;
    input [3:0] addr;
    begin
      case (addr)
        `OFS_COMPARATOR_TRIGGER: decode_sel = 2'h1;
        `OFS_LOGIC_CELLS_MISC:   decode_sel = 2'h2;
        default:                 decode_sel = 2'h0;
      endcase
    end
  endfunction

  // Answers okay for a mapped register and an error for a hole in the map.
  // The error path changes no state, so software can probe the map safely.
  function [1:0] resp_for;
    input [1:0] sel;
    begin
      resp_for = (sel != 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
    end
  endfunction

  // Both write halves are present and no response is still pending.
  // Waiting for the response channel keeps two writes from sharing one answer.
  wire       do_write = waddr_ok_q & wdata_ok_q & ~s_axi_bvalid;
  wire [1:0] wr_sel   = decode_sel(waddr_q);
  wire [1:0] rd_sel   = decode_sel(s_axi_araddr);
  wire       hit_a    = wr_sel[0];
  wire       hit_b    = wr_sel[1];

  // Write path: address and data are taken in either order, then the write commits.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      waddr_q       <= 4'h0;
      waddr_ok_q    <= 1'b0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      wdata_ok_q    <= 1'b0;
      cmp_trig_q    <= `RST_COMPARATOR_TRIGGER;
      cells_misc_q  <= `RST_LOGIC_CELLS_MISC;
    end else begin
      // Ready is a one-cycle pulse, so a valid that is still held is not taken twice.
      s_axi_awready <= ~waddr_ok_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wdata_ok_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_q    <= s_axi_awaddr;
        waddr_ok_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q    <= s_axi_wdata;
        wstrb_q    <= s_axi_wstrb;
        wdata_ok_q <= 1'b1;
      end
      // Commit: update the addressed register and raise the response together.
      if (do_write) begin
        waddr_ok_q   <= 1'b0;
        wdata_ok_q   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= resp_for(wr_sel);
        if (hit_a) begin
          // Only bits 8 and 3 exist; the rest stay zero.
          cmp_trig_q <= merge(cmp_trig_q, wdata_q, wstrb_q,
                              `MASK_COMPARATOR_TRIGGER);
        end
        if (hit_b) begin
          cells_misc_q <= merge(cells_misc_q, wdata_q, wstrb_q,
                                `MASK_LOGIC_CELLS_MISC);
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path: one cycle to accept, data valid the cycle after.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      // A new read is refused while the previous data still wait for the master.
      // The data then stand until the master takes them.
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= resp_for(rd_sel);
        case (rd_sel)
          2'h1: begin
            s_axi_rdata <= {16'h0000, cmp_trig_q & `MASK_COMPARATOR_TRIGGER};
          end
          2'h2: begin
            s_axi_rdata <= {16'h0000, cells_misc_q & `MASK_LOGIC_CELLS_MISC};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Flags of the first register, registered copies of the stored bits.
  // Each flag comes straight from a flip-flop, so a peripheral never sees a decode glitch.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_one_off  <= 1'b0;
      pattern_trigger_off <= 1'b0;
    end else begin
      comparator_one_off  <= cmp_trig_q[`POS_COMPARATOR_ONE_OFF];
      pattern_trigger_off <= cmp_trig_q[`POS_PATTERN_TRIGGER_OFF];
    end
  end

  // Flags of the second register, registered copies of the stored bits.
  // All of them clear at reset, so every unit starts enabled.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opamp_modules_off    <= 1'b0;
      nibble_tx_one_off    <= 1'b0;
      deadman_timer_off    <= 1'b0;
      logic_cell_four_off  <= 1'b0;
      logic_cell_three_off <= 1'b0;
      logic_cell_two_off   <= 1'b0;
      logic_cell_one_off   <= 1'b0;
      current_source_off   <= 1'b0;
    end else begin
      opamp_modules_off    <= cells_misc_q[`POS_OPAMP_MODULES_OFF];
      nibble_tx_one_off    <= cells_misc_q[`POS_NIBBLE_TX_ONE_OFF];
      deadman_timer_off    <= cells_misc_q[`POS_DEADMAN_TIMER_OFF];
      logic_cell_four_off  <= cells_misc_q[`POS_LOGIC_CELL_FOUR_OFF];
      logic_cell_three_off <= cells_misc_q[`POS_LOGIC_CELL_THREE_OFF];
      logic_cell_two_off   <= cells_misc_q[`POS_LOGIC_CELL_TWO_OFF];
      logic_cell_one_off   <= cells_misc_q[`POS_LOGIC_CELL_ONE_OFF];
      current_source_off   <= cells_misc_q[`POS_CURRENT_SOURCE_OFF];
    end
  end

endmodule // peripheral_disable_regs

`default_nettype wire

// [dv/peripheral_disable_regs_checker.sv]
// Assertion checker for the peripheral disable register bank.
`timescale 1ns/1ns
`default_nettype none
module peripheral_disable_regs_checker (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Write request channels.
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // Read data channel.
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Disable flags.
  input wire logic        comparator_one_off,
  input wire logic        pattern_trigger_off,
  input wire logic        opamp_modules_off,
  input wire logic        nibble_tx_one_off,
  input wire logic        deadman_timer_off,
  input wire logic        logic_cell_four_off,
  input wire logic        logic_cell_three_off,
  input wire logic        logic_cell_two_off,
  input wire logic        logic_cell_one_off,
  input wire logic        current_source_off
);
  // A write taken on both channels at one edge, per register.
  wire logic tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic w0 = tk && s_axi_awaddr == 4'h0;
  wire logic w4 = tk && s_axi_awaddr == 4'h4;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // The register commits one edge after the take, and the flag follows one edge later.
  a_cmp_flag_follows: assert property (
    w0 && s_axi_wstrb[1] |-> ##3 comparator_one_off == $past(s_axi_wdata[8], 3))
    else $error("comparator flag wrong");
  a_trig_flag_follows: assert property (
    w0 && s_axi_wstrb[0] |-> ##3 pattern_trigger_off == $past(s_axi_wdata[3], 3))
    else $error("trigger flag wrong");
  a_unused_read_zero: assert property (
    s_axi_rvalid |-> (s_axi_rdata & 32'hFFFFD6C1) == 32'h0) else $error("unused bits set");
  a_nibble_flag_follows: assert property (
    w4 && s_axi_wstrb[1] |-> ##3 nibble_tx_one_off == $past(s_axi_wdata[11], 3))
    else $error("nibble flag wrong");
  a_cell_flags_follow: assert property (
    w4 && s_axi_wstrb[0] |-> ##3 {logic_cell_four_off, logic_cell_three_off,
    logic_cell_two_off, logic_cell_one_off} == $past(s_axi_wdata[5:2], 3))
    else $error("cell flags wrong");
  a_misc_flags_follow: assert property (
    w4 && s_axi_wstrb[1:0] == 2'h3 |-> ##3 {opamp_modules_off, deadman_timer_off,
    current_source_off} == {$past(s_axi_wdata[13], 3), $past(s_axi_wdata[8], 3),
    $past(s_axi_wdata[1], 3)}) else $error("misc flags wrong");
endmodule // peripheral_disable_regs_checker
bind peripheral_disable_regs peripheral_disable_regs_checker chk (
  .sys_clk              (sys_clk),
  .rst_n                (rst_n),
  .s_axi_awaddr         (s_axi_awaddr),
  .s_axi_awvalid        (s_axi_awvalid),
  .s_axi_awready        (s_axi_awready),
  .s_axi_wdata          (s_axi_wdata),
  .s_axi_wstrb          (s_axi_wstrb),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_wready         (s_axi_wready),
  .s_axi_rdata          (s_axi_rdata),
  .s_axi_rvalid         (s_axi_rvalid),
  .comparator_one_off   (comparator_one_off),
  .pattern_trigger_off  (pattern_trigger_off),
  .opamp_modules_off    (opamp_modules_off),
  .nibble_tx_one_off    (nibble_tx_one_off),
  .deadman_timer_off    (deadman_timer_off),
  .logic_cell_four_off  (logic_cell_four_off),
  .logic_cell_three_off (logic_cell_three_off),
  .logic_cell_two_off   (logic_cell_two_off),
  .logic_cell_one_off   (logic_cell_one_off),
  .current_source_off   (current_source_off)
);
`default_nettype wire

// [dv/test_peripheral_disable_regs.sv]
// Self-checking bench for the peripheral disable register bank.
`timescale 1ns/1ns
`default_nettype none
module test_peripheral_disable_regs;
  // Signals named as the design ports.
  logic        sys_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, comparator_one_off, pattern_trigger_off;
  logic        opamp_modules_off, nibble_tx_one_off, deadman_timer_off, logic_cell_four_off;
  logic        logic_cell_three_off, logic_cell_two_off, logic_cell_one_off, current_source_off;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] sh [2];
  int          num_errors = 0, check_count = 0, i, r;
  wire logic [9:0] flags = {comparator_one_off, pattern_trigger_off, opamp_modules_off,
    nibble_tx_one_off, deadman_timer_off, logic_cell_four_off, logic_cell_three_off,
    logic_cell_two_off, logic_cell_one_off, current_source_off};
  peripheral_disable_regs dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .comparator_one_off(comparator_one_off), .pattern_trigger_off(pattern_trigger_off),
    .opamp_modules_off(opamp_modules_off), .nibble_tx_one_off(nibble_tx_one_off),
    .deadman_timer_off(deadman_timer_off), .logic_cell_four_off(logic_cell_four_off),
    .logic_cell_three_off(logic_cell_three_off), .logic_cell_two_off(logic_cell_two_off),
    .logic_cell_one_off(logic_cell_one_off), .current_source_off(current_source_off)
  );
  // Clock of 100 ns period.
  initial forever #50 sys_clk = ~sys_clk;
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Writes a register, reads it back and checks the flag outputs.
  task automatic acc(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s);
    logic ok;
    ok = (a == 4'h0 || a == 4'h4);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {16'hA5A5, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    chk(s_axi_bresp, ok ? 2'h0 : 2'h2);
    for (int b = 0; b < 2; b++) if (ok && s[b]) sh[a[2]][8*b +: 8] = d[8*b +: 8];
    sh[a[2]] = sh[a[2]] & (a[2] ? 16'h293E : 16'h0108);
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, ok ? 2'h0 : 2'h2);
    chk(s_axi_rdata, ok ? {16'h0, sh[a[2]]} : 32'h0);
    chk(flags, {sh[0][8], sh[0][3], sh[1][13], sh[1][11], sh[1][8], sh[1][5:1]});
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cuts a hung handshake short.
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish;
  end
  // Reset, walking ones, full writes, byte lanes and two unmapped places.
  initial begin
    sh[0] = 16'h0;
    sh[1] = 16'h0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(4'h0, 16'h0, 4'h0);
    acc(4'h4, 16'h0, 4'h0);
    for (r = 0; r < 2; r++)
      for (i = 0; i < 16; i++) acc(r ? 4'h4 : 4'h0, 16'h1 << i, 4'h3);
    acc(4'h0, 16'hFFFF, 4'hF);
    acc(4'h4, 16'hFFFF, 4'hF);
    acc(4'h0, 16'h0, 4'h1);
    acc(4'h4, 16'h0, 4'h2);
    acc(4'h8, 16'h0, 4'hF);
    acc(4'hC, 16'hFFFF, 4'h3);
    // A reset in mid-run must clear every flag that is still set.
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    sh[0] = 16'h0;
    sh[1] = 16'h0;
    acc(4'h0, 16'h0, 4'h0);
    acc(4'h4, 16'h0, 4'h0);
    tally_and_finish;
  end
endmodule // test_peripheral_disable_regs
`default_nettype wire
